// ---- hdl/lam_top.sv ----
// receive frame screening and auto-mode link handling of a d-channel controller
// assumes: bit-level receiver and transmitter on clk_sys_i drive the frame inputs
`include "lam_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lam_top #(
  parameter int TICK_CYC = (`LAM_TICK_NS + `LAM_CLK_NS - 1) / `LAM_CLK_NS
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              rx_start_i,
  input  wire logic              rx_open_flag_i,
  input  wire logic              rx_byte_i,
  input  wire logic              rx_end_i,
  input  wire logic              rx_close_flag_i,
  input  wire logic              rx_partial_i,
  input  wire logic              rx_crc_ok_i,
  input  wire logic              rx_single_addr_i,
  input  wire logic              rx_sapi_ok_i,
  input  wire logic              rx_overflow_i,
  input  wire lam_pkg::lam_ftype_t rx_ftype_i,
  input  wire logic              tx_frame_done_i,
  input  wire logic              tx_collision_i,
  input  wire logic              peer_ack_i,
  input  wire logic              peer_reject_i,
  input  wire logic              peer_rr_i,
  input  wire logic              peer_rnr_i,
  input  wire logic              sframe_seen_i,
  input  wire logic              proto_err_i,
  output logic                   rx_message_end_irq_o,
  output logic                   rx_pool_full_irq_o,
  output logic                   tx_pool_ready_irq_o,
  output logic                   tx_repeat_irq_o,
  output logic                   timer_expiry_irq_o,
  output logic                   peer_status_change_irq_o,
  output logic                   protocol_error_irq_o,
  output logic                   send_poll_o
);
  // ==========================================================
  // register port decode
  logic [7:0]          mode_q, timer_q;
  logic                cmd_wr, sframe_detect_flag, ovf_acc;
  logic                rx_release_cmd, receiver_reset_cmd, send_numbered_info_cmd;
  logic                send_transparent_cmd, start_timer_cmd;
  logic                auto_mode, internal_timer_select, mode_to_nam;
  lam_pkg::lam_rx_t    rx_q;
  lam_pkg::lam_link_t  link_q;
  logic [11:0]         cnt_q;
  logic                rab_q, rdo_q, crc_q, wfa_q, xif_q, peer_busy_q;
  logic [2:0]          rc_q;
  assign cmd_wr                 = reg_wr_i && reg_addr_i == `LAM_A_CMD;
  assign rx_release_cmd         = cmd_wr && reg_wdata_i[`LAM_CMD_RMC];
  assign receiver_reset_cmd     = cmd_wr && (reg_wdata_i[`LAM_CMD_RECEIVER_RESET_CMD] || reg_wdata_i[`LAM_CMD_RHR]);
  assign send_numbered_info_cmd = cmd_wr && reg_wdata_i[`LAM_CMD_XIF];
  assign send_transparent_cmd   = cmd_wr && reg_wdata_i[`LAM_CMD_XTF];
  assign start_timer_cmd        = cmd_wr && reg_wdata_i[`LAM_CMD_STI];
  assign auto_mode              = !mode_q[`LAM_MODE_NAM];
  assign internal_timer_select  = mode_q[`LAM_MODE_TMD];
  assign mode_to_nam            = reg_wr_i && reg_addr_i == `LAM_A_MODE && reg_wdata_i[`LAM_MODE_NAM];

  // mode and timer registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q  <= `LAM_MODE_RST;
      timer_q <= `LAM_TMR_RST;
    end else if (reg_wr_i && reg_addr_i == `LAM_A_MODE) begin
      mode_q  <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `LAM_A_TIMER) begin
      timer_q <= reg_wdata_i;
    end
  end

  // read data, one cycle after the strobe; peer bits hidden outside auto
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `LAM_A_MODE:   reg_rdata_o <= mode_q;
        `LAM_A_RXSTAT: reg_rdata_o <= {1'b0, rdo_q, crc_q, rab_q, 4'h0};
        `LAM_A_CNT_LO: reg_rdata_o <= cnt_q[7:0];
        `LAM_A_CNT_HI: reg_rdata_o <= {4'h0, cnt_q[11:8]};
        `LAM_A_LINK:   reg_rdata_o <= !auto_mode ? 8'h00 :
                                      {sframe_detect_flag, wfa_q, link_q == lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG, 1'b0,
                                       link_q == lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG ? `LAM_LK_TIMER_RECOVERY_FLAG_CODE
                                                                      : `LAM_LK_MFE_CODE};
        `LAM_A_GSTAT:  reg_rdata_o <= {7'h00, auto_mode && peer_busy_q};
        `LAM_A_TIMER:  reg_rdata_o <= timer_q;
        default:       reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // receive screening
  logic is_s, is_i, short_len, discard, crc_good;
  logic [11:0] len_min;
  assign is_s = rx_ftype_i == lam_pkg::LAM_FT_S;
  assign is_i = rx_ftype_i == lam_pkg::LAM_FT_I;
  // minimum length per class; outside S frames a partial octet above it passes the length check
  assign len_min   = is_s ? `LAM_MIN_S : (is_i ? `LAM_MIN_I : `LAM_MIN_U);
  assign short_len = is_s ? (cnt_q < len_min)
                          : (cnt_q < len_min || (cnt_q == len_min && !rx_partial_i));
  assign discard   = rx_single_addr_i || !rx_sapi_ok_i
                  || (is_s && !rx_close_flag_i)
                  || short_len
                  || (rx_partial_i && (is_s || (is_i && mode_q[`LAM_MODE_BUSY])))
                  || (is_s && !rx_crc_ok_i);
  // partial octet, bad check or abort all report check-sequence bad
  assign crc_good  = rx_close_flag_i && !rx_partial_i && rx_crc_ok_i;

  lam_flag u_ovf (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (rx_q == lam_pkg::LAM_RX_FRAME && rx_overflow_i && !is_s),
    .clr_i     (rx_start_i),
    .flag_o    (ovf_acc)
  );

  // frame state, byte count and held status
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_q                 <= lam_pkg::LAM_RX_IDLE;
      cnt_q                <= 12'h000;
      rab_q                <= 1'b0;
      rdo_q                <= 1'b0;
      crc_q                <= 1'b0;
      rx_message_end_irq_o <= 1'b0;
      rx_pool_full_irq_o   <= 1'b0;
    end else begin
      rx_message_end_irq_o <= 1'b0;
      rx_pool_full_irq_o   <= 1'b0;
      if (receiver_reset_cmd) begin
        rx_q  <= lam_pkg::LAM_RX_IDLE;
        cnt_q <= 12'h000;
      end else begin
        unique case (rx_q)
          lam_pkg::LAM_RX_IDLE: begin
            if (rx_start_i && rx_open_flag_i) begin
              rx_q  <= lam_pkg::LAM_RX_FRAME;
              cnt_q <= 12'h000;
            end
          end
          lam_pkg::LAM_RX_FRAME: begin
            if (rx_end_i) begin
              if (discard) begin
                rx_q <= lam_pkg::LAM_RX_IDLE;
              end else begin
                rx_q                 <= lam_pkg::LAM_RX_HOLD;
                rx_message_end_irq_o <= 1'b1;
                rab_q                <= !rx_close_flag_i;
                rdo_q                <= ovf_acc || rx_overflow_i;
                crc_q                <= crc_good;
              end
            end else if (rx_byte_i) begin
              cnt_q <= cnt_q + 12'h001;
              if (!is_s && cnt_q[4:0] == 5'h1F) begin
                rx_pool_full_irq_o <= 1'b1;
              end
            end
          end
          lam_pkg::LAM_RX_HOLD: begin
            if (rx_release_cmd) begin
              rx_q <= lam_pkg::LAM_RX_IDLE;
            end
          end
          default: rx_q <= lam_pkg::LAM_RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // acknowledgement timer, runs only in states 7 and 8
  logic [$clog2(TICK_CYC)-1:0] tick_q;
  logic [4:0] per_q;
  logic       run_q, t_exp, tmr_start, tmr_stop;
  logic       at_ready, rep_ev, ack_ev;
  assign t_exp    = run_q && auto_mode && tick_q == ($clog2(TICK_CYC))'(TICK_CYC - 1) && per_q <= 5'h01;
  assign ack_ev   = auto_mode && wfa_q && peer_ack_i;
  assign rep_ev   = auto_mode && xif_q && wfa_q && (peer_reject_i || tx_collision_i);
  assign at_ready = auto_mode && internal_timer_select;
  assign tmr_start = (at_ready && start_timer_cmd)
                  || (auto_mode && xif_q && wfa_q && tx_frame_done_i)
                  || (t_exp && rc_q < timer_q[7:5]);
  assign tmr_stop  = !auto_mode || ack_ev || rep_ev || t_exp
                  || (reg_wr_i && reg_addr_i == `LAM_A_TIMER);

  // tick prescaler and period count
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q  <= 1'b0;
      tick_q <= '0;
      per_q  <= 5'h00;
    end else if (tmr_start) begin
      run_q  <= 1'b1;
      tick_q <= '0;
      per_q  <= timer_q[4:0];
    end else if (tmr_stop) begin
      run_q  <= 1'b0;
    end else if (run_q) begin
      tick_q <= (tick_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) ? '0 : tick_q + 1'b1;
      if (tick_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
        per_q <= per_q - 5'h01;
      end
    end
  end

  // ==========================================================
  // link state, retry counter and transmit outcomes
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_q                   <= lam_pkg::LAM_LK_OFF;
      rc_q                     <= 3'h0;
      wfa_q                    <= 1'b0;
      xif_q                    <= 1'b0;
      peer_busy_q              <= 1'b0;
      tx_pool_ready_irq_o      <= 1'b0;
      tx_repeat_irq_o          <= 1'b0;
      timer_expiry_irq_o       <= 1'b0;
      peer_status_change_irq_o <= 1'b0;
      protocol_error_irq_o     <= 1'b0;
      send_poll_o              <= 1'b0;
    end else begin
      tx_pool_ready_irq_o      <= 1'b0;
      tx_repeat_irq_o          <= 1'b0;
      timer_expiry_irq_o       <= 1'b0;
      send_poll_o              <= 1'b0;
      peer_status_change_irq_o <= auto_mode && ((peer_rnr_i && !peer_busy_q) || (peer_rr_i && peer_busy_q));
      protocol_error_irq_o     <= auto_mode && proto_err_i;
      if (peer_rnr_i) begin
        peer_busy_q <= 1'b1;
      end else if (peer_rr_i) begin
        peer_busy_q <= 1'b0;
      end
      if (!auto_mode) begin
        // plain mode: ready means sent, repeat means collision
        link_q              <= lam_pkg::LAM_LK_OFF;
        rc_q                <= 3'h0;
        wfa_q               <= 1'b0;
        xif_q               <= 1'b0;
        tx_pool_ready_irq_o <= tx_frame_done_i;
        tx_repeat_irq_o     <= tx_collision_i;
      end else begin
        if (link_q == lam_pkg::LAM_LK_OFF) begin
          link_q <= lam_pkg::LAM_LK_MFE;
        end
        if (send_transparent_cmd) begin
          xif_q <= 1'b0;
        end else if (send_numbered_info_cmd && internal_timer_select) begin
          xif_q <= 1'b1;
          wfa_q <= 1'b1;
        end
        if (!xif_q) begin
          tx_pool_ready_irq_o <= tx_frame_done_i && !mode_to_nam;
          tx_repeat_irq_o     <= tx_collision_i;
        end
        if (at_ready && start_timer_cmd) begin
          link_q <= lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG;
          rc_q   <= 3'h0;
        end else if (rep_ev) begin
          tx_repeat_irq_o <= 1'b1;
          link_q          <= lam_pkg::LAM_LK_MFE;
          rc_q            <= 3'h0;
          wfa_q           <= 1'b0;
        end else if (ack_ev) begin
          tx_pool_ready_irq_o <= !mode_to_nam;
          wfa_q               <= 1'b0;
          if (link_q == lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG) begin
            link_q <= lam_pkg::LAM_LK_MFE;
            rc_q   <= 3'h0;
          end
        end else if (t_exp) begin
          if (rc_q < timer_q[7:5]) begin
            send_poll_o <= 1'b1;
            rc_q        <= rc_q + 3'h1;
            link_q      <= lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG;
          end else begin
            timer_expiry_irq_o  <= 1'b1;
            tx_pool_ready_irq_o <= !mode_to_nam;
            wfa_q               <= 1'b0;
          end
        end
      end
    end
  end

  // supervisory frames seen, cleared by reading the link state
  lam_flag u_sframe_detect_flag (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (auto_mode && sframe_seen_i),
    .clr_i     (reg_rd_i && reg_addr_i == `LAM_A_LINK),
    .flag_o    (sframe_detect_flag)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_frame_end;
    rx_q == lam_pkg::LAM_RX_FRAME && rx_end_i && !receiver_reset_cmd;
  endsequence
  sequence s_reported;
    ##1 rx_message_end_irq_o && rx_q == lam_pkg::LAM_RX_HOLD;
  endsequence

  a_no_open_drop: assert property (rx_q == lam_pkg::LAM_RX_IDLE && rx_start_i && !rx_open_flag_i
    |=> rx_q == lam_pkg::LAM_RX_IDLE) else $error("frame without opening flag accepted");
  a_abort_s_drop: assert property (s_frame_end and (is_s && !rx_close_flag_i)
    |=> !rx_message_end_irq_o) else $error("aborted s-frame reported");
  a_abort_flag: assert property (s_frame_end and (!is_s && !rx_close_flag_i && !discard)
    |-> s_reported ##0 rab_q && !crc_q) else $error("abort not flagged");
  a_short_drop: assert property (s_frame_end and (is_i && cnt_q == `LAM_MIN_I && !rx_partial_i)
    |=> rx_q == lam_pkg::LAM_RX_IDLE && !rx_message_end_irq_o) else $error("short i-frame kept");
  a_bad_check: assert property (s_frame_end and (!discard && (rx_partial_i || !rx_crc_ok_i))
    |-> s_reported ##0 !crc_q) else $error("bad frame shows good check");
  a_addr_drop: assert property (s_frame_end and rx_single_addr_i
    |=> !rx_message_end_irq_o) else $error("single address frame reported");
  a_overflow: assert property (s_frame_end and (!discard && (ovf_acc || rx_overflow_i))
    |-> s_reported ##0 rdo_q) else $error("overflow not flagged");
  a_hold_status: assert property (rx_q == lam_pkg::LAM_RX_HOLD && !rx_release_cmd && !receiver_reset_cmd
    |=> $stable(crc_q) && $stable(rab_q) && $stable(rdo_q)) else $error("held status changed");
  a_rc_clear: assert property (link_q == lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG ##1 link_q == lam_pkg::LAM_LK_MFE
    |-> rc_q == 3'h0) else $error("retry counter kept after recovery");
  a_sti_timer_recovery_flag: assert property (at_ready && start_timer_cmd && !mode_to_nam
    |=> link_q == lam_pkg::LAM_LK_TIMER_RECOVERY_FLAG && rc_q == 3'h0) else $error("start timer ignored");
  a_repeat_mfe: assert property (rep_ev && !(at_ready && start_timer_cmd)
    |=> tx_repeat_irq_o && link_q == lam_pkg::LAM_LK_MFE) else $error("repeat without state 7");
  a_nam_quiet: assert property (!auto_mode |=> !run_q && !send_poll_o && !timer_expiry_irq_o)
    else $error("timer active outside auto mode");
endmodule
`default_nettype wire

// ---- common/lam_map.svh ----
// register map, field positions, reset values and timing constants
// assumes: included by bare name from design and bench files
`ifndef LAM_MAP_SVH
`define LAM_MAP_SVH
// ==========================================================
// register indices on the plain register port
`define LAM_A_MODE    4'h0
`define LAM_A_CMD     4'h1
`define LAM_A_RXSTAT  4'h2
`define LAM_A_CNT_LO  4'h3
`define LAM_A_CNT_HI  4'h4
`define LAM_A_LINK    4'h5
`define LAM_A_GSTAT   4'h6
`define LAM_A_TIMER   4'h7
// ==========================================================
// mode register fields
`define LAM_MODE_NAM  0
`define LAM_MODE_TMD  1
`define LAM_MODE_BUSY 2
`define LAM_MODE_RST  8'h01
// command register fields (write only, self clearing)
`define LAM_CMD_RMC   0
`define LAM_CMD_RECEIVER_RESET_CMD  1
`define LAM_CMD_XIF   2
`define LAM_CMD_XTF   3
`define LAM_CMD_STI   4
`define LAM_CMD_TRANSMITTER_RESET_CMD  5
`define LAM_CMD_RHR   6
// receive status fields
`define LAM_RS_RDO    6
`define LAM_RS_CRC    5
`define LAM_RS_RAB    4
// link state register fields
`define LAM_LK_SFRAME_DETECT_FLAG   7
`define LAM_LK_WFA    6
`define LAM_LK_TIMER_RECOVERY_FLAG   5
`define LAM_LK_MFE_CODE  4'h7
`define LAM_LK_TIMER_RECOVERY_FLAG_CODE 4'h8
// general status fields
`define LAM_GS_PEER_BUSY_FLAG   0
// timer register: retry count in [7:5], period in ticks in [4:0]
`define LAM_TMR_RST   8'h61
// ==========================================================
// frame screening figures
`define LAM_POOL_BYTES 12'h020
`define LAM_MIN_U     12'h004
`define LAM_MIN_I     12'h005
`define LAM_MIN_S     12'h006
// timing
`define LAM_CLK_NS    25
`define LAM_TICK_NS   1000000
`endif

// ---- common/lam_pkg.sv ----
// types shared by the frame checker and its helpers
// assumes: compiled before any design file
package lam_pkg;
  // ==========================================================
  // frame class decoded from the control field
  typedef enum logic [1:0] {LAM_FT_I, LAM_FT_S, LAM_FT_U, LAM_FT_UNDEF} lam_ftype_t;
  // link state machine
  typedef enum logic [1:0] {LAM_LK_OFF, LAM_LK_MFE, LAM_LK_TIMER_RECOVERY_FLAG} lam_link_t;
  // receive screening machine
  typedef enum logic [1:0] {LAM_RX_IDLE, LAM_RX_FRAME, LAM_RX_HOLD} lam_rx_t;
endpackage

// ---- hdl/lam_flag.sv ----
// sticky status flag where a set beats a simultaneous clear
// assumes: set and clear come from logic on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module lam_flag (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  // ==========================================================
  // set wins over clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/lam_peer.sv ----
// remote link entity model: frames and peer events toward the block
// assumes: bench calls its tasks; all changes follow a rising clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module lam_peer (
  input  wire logic          clk_sys_i,
  output logic               start_o,
  output logic               byte_o,
  output logic               end_o,
  output logic [6:0]         flg_o,
  output lam_pkg::lam_ftype_t ftype_o,
  output logic [7:0]         ev_o
);
  // ==========================================================
  // idle lines at time zero
  initial begin
    {start_o, byte_o, end_o, flg_o, ev_o} = '0;
    ftype_o = lam_pkg::LAM_FT_U;
  end
  // one frame: start, octets, end; flg is {open,close,part,crc,single,sapi,ovf}
  task automatic frame(input lam_pkg::lam_ftype_t t, input int nb, input logic [6:0] f);
    @(posedge clk_sys_i);
    start_o <= 1'b1;
    flg_o   <= f & 7'h40;
    ftype_o <= t;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_sys_i);
      start_o  <= 1'b0;
      byte_o   <= 1'b1;
      flg_o[0] <= f[0] && (i == nb - 1);
    end
    @(posedge clk_sys_i);
    byte_o <= 1'b0;
    end_o  <= 1'b1;
    flg_o  <= f & 7'h7E;
    @(posedge clk_sys_i);
    end_o   <= 1'b0;
    flg_o   <= ~f & 7'h7E; // stale qualifiers never repeat the last frame
    ftype_o <= lam_pkg::lam_ftype_t'(~t);
  endtask
  // one-cycle link event
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    ev_o[k] <= 1'b1;
    @(posedge clk_sys_i);
    ev_o <= 8'h00;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_lapd_auto_mode_frame_checks.sv ----
// self-checking bench: register port, frame screening, auto-mode link events
// assumes: lam_peer drives frame and link inputs; timer tick shortened to 4 cycles
`include "lam_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_lapd_auto_mode_frame_checks;
  localparam lam_pkg::lam_ftype_t FI = lam_pkg::LAM_FT_I;
  localparam lam_pkg::lam_ftype_t FS = lam_pkg::LAM_FT_S;
  localparam lam_pkg::lam_ftype_t FU = lam_pkg::LAM_FT_U;
  logic                clk_sys_i, sys_rst_i, reg_wr, reg_rd, st, by, en;
  logic [3:0]          reg_addr;
  logic [7:0]          reg_wdata, reg_rdata, ev, irq;
  logic [6:0]          flg;
  lam_pkg::lam_ftype_t ft;
  int                  n [8];
  int                  error_cnt, checks;
  // ==========================================================
  // clock and output pulse counters
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    for (int k = 0; k < 8; k++)
      if (irq[k] === 1'b1)
        n[k]++;
  lam_top #(.TICK_CYC(4)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rx_start_i(st),
    .rx_open_flag_i(flg[6]), .rx_byte_i(by), .rx_end_i(en), .rx_close_flag_i(flg[5]),
    .rx_partial_i(flg[4]), .rx_crc_ok_i(flg[3]), .rx_single_addr_i(flg[2]), .rx_sapi_ok_i(flg[1]),
    .rx_overflow_i(flg[0]), .rx_ftype_i(ft), .tx_frame_done_i(ev[0]), .tx_collision_i(ev[1]),
    .peer_ack_i(ev[2]), .peer_reject_i(ev[3]), .peer_rr_i(ev[4]), .peer_rnr_i(ev[5]),
    .sframe_seen_i(ev[6]), .proto_err_i(ev[7]), .rx_message_end_irq_o(irq[0]),
    .rx_pool_full_irq_o(irq[1]), .tx_pool_ready_irq_o(irq[2]), .tx_repeat_irq_o(irq[3]),
    .timer_expiry_irq_o(irq[4]), .peer_status_change_irq_o(irq[5]),
    .protocol_error_irq_o(irq[6]), .send_poll_o(irq[7]));
  lam_peer peer (.clk_sys_i(clk_sys_i), .start_o(st), .byte_o(by), .end_o(en), .flg_o(flg),
    .ftype_o(ft), .ev_o(ev));
  // ==========================================================
  // compare, register access, verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1 chk(nm, {8'h00, reg_rdata & m}, {8'h00, exp});
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one frame, then end and pool-full counts, status, count and release
  task automatic fr(input lam_pkg::lam_ftype_t t, input int nb, input logic [6:0] f, input int me,
                    input logic [7:0] rs);
    int m0, p0;
    m0 = n[0];
    p0 = n[1];
    peer.frame(t, nb, f);
    repeat (3) @(posedge clk_sys_i);
    chk("message end", 16'(n[0] - m0), 16'(me));
    chk("pool full", 16'(n[1] - p0), 16'(nb / 32));
    if (me == 1) begin
      rd("rx status", `LAM_A_RXSTAT, 8'h70, rs);
      rd("count low", `LAM_A_CNT_LO, 8'hFF, 8'(nb));
      wr(`LAM_A_CMD, 8'h01);
    end
  endtask
  // link event after an optional command and frame-sent pulse
  task automatic lk(input logic [7:0] cmd, input int k, input int idx, input string nm);
    int c0;
    c0 = n[idx];
    if (cmd != 8'h00) begin
      wr(`LAM_A_CMD, cmd);
      peer.pulse(0);
    end
    peer.pulse(k);
    repeat (3) @(posedge clk_sys_i);
    chk(nm, 16'(n[idx] - c0), 16'd1);
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    error_cnt++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    int m0;
    sys_rst_i = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd("mode", `LAM_A_MODE, 8'hFF, 8'h01);
    rd("timer", `LAM_A_TIMER, 8'hFF, 8'h61);
    rd("link", `LAM_A_LINK, 8'hFF, 8'h00);
    rd("command", `LAM_A_CMD, 8'hFF, 8'h00);
    rd("unmapped", 4'hF, 8'hFF, 8'h00);
    $display("reset values done");
    fr(FI, 8, 7'h2A, 0, 8'h00);
    fr(FS, 8, 7'h4A, 0, 8'h00);
    fr(FI, 8, 7'h42, 1, 8'h10);
    fr(FU, 4, 7'h6A, 0, 8'h00);
    fr(FI, 5, 7'h6A, 0, 8'h00);
    fr(FS, 5, 7'h6A, 0, 8'h00);
    fr(FU, 5, 7'h6A, 1, 8'h20);
    fr(FU, 4, 7'h7A, 1, 8'h00);
    fr(FI, 5, 7'h7A, 1, 8'h00);
    fr(FS, 8, 7'h7A, 0, 8'h00);
    fr(FI, 8, 7'h7A, 1, 8'h00);
    wr(`LAM_A_MODE, 8'h05);
    fr(FI, 8, 7'h7A, 0, 8'h00);
    wr(`LAM_A_MODE, 8'h01);
    fr(FS, 8, 7'h62, 0, 8'h00);
    fr(FU, 8, 7'h62, 1, 8'h00);
    fr(FI, 8, 7'h6E, 0, 8'h00);
    fr(FI, 8, 7'h68, 0, 8'h00);
    fr(FI, 8, 7'h6B, 1, 8'h60);
    fr(FI, 33, 7'h6A, 1, 8'h20);
    // status held while unreleased; later frame ignored
    m0 = n[0];
    peer.frame(FU, 5, 7'h6A);
    peer.frame(FI, 8, 7'h6B);
    repeat (3) @(posedge clk_sys_i);
    chk("held end", 16'(n[0] - m0), 16'd1);
    rd("held status", `LAM_A_RXSTAT, 8'h70, 8'h20);
    wr(`LAM_A_CMD, 8'h01);
    $display("frame screening done");
    wr(`LAM_A_MODE, 8'h02);
    wr(`LAM_A_TIMER, 8'h21);
    lk(8'h04, 2, 2, "ready after ack");
    rd("link after ack", `LAM_A_LINK, 8'h2F, 8'h07);
    lk(8'h04, 3, 3, "repeat after reject");
    lk(8'h04, 1, 3, "repeat after collision");
    rd("link after repeat", `LAM_A_LINK, 8'h2F, 8'h07);
    lk(8'h00, 5, 5, "peer busy change");
    rd("peer busy", `LAM_A_GSTAT, 8'h01, 8'h01);
    lk(8'h00, 4, 5, "peer ready change");
    rd("peer ready", `LAM_A_GSTAT, 8'h01, 8'h00);
    lk(8'h00, 7, 6, "protocol error");
    peer.pulse(6);
    rd("sframe seen", `LAM_A_LINK, 8'h80, 8'h80);
    rd("sframe cleared", `LAM_A_LINK, 8'h80, 8'h00);
    m0 = n[2];
    wr(`LAM_A_CMD, 8'h04);
    peer.pulse(0);
    repeat (2) @(posedge clk_sys_i);
    chk("no ready before ack", 16'(n[2] - m0), 16'd0);
    m0 = n[7];
    repeat (60) @(posedge clk_sys_i);
    chk("polls", 16'(n[7] - m0), 16'd1);
    chk("timer expiry", 16'(n[4]), 16'd1);
    chk("ready with expiry", 16'(n[2]), 16'd2);
    wr(`LAM_A_CMD, 8'h10);
    rd("link recovery", `LAM_A_LINK, 8'h2F, 8'h28);
    lk(8'h04, 2, 2, "ready in recovery");
    lk(8'h08, 1, 3, "repeat after transparent");
    rd("ack state saved", `LAM_A_LINK, 8'h6F, 8'h07);
    wr(`LAM_A_MODE, 8'h01);
    wr(`LAM_A_TIMER, 8'h00);
    rd("link non-auto", `LAM_A_LINK, 8'hFF, 8'h00);
    rd("busy non-auto", `LAM_A_GSTAT, 8'hFF, 8'h00);
    lk(8'h00, 0, 2, "ready non-auto");
    lk(8'h00, 1, 3, "repeat non-auto");
    repeat (20) @(posedge clk_sys_i);
    wr(`LAM_A_CMD, 8'h60);
    rd("count after reset", `LAM_A_CNT_LO, 8'hFF, 8'h00);
    $display("link handling done");
    conclude();
  end
endmodule
`default_nettype wire
